/* hw/pcsic_pkg.sv */
// shared constants and types of the pc, stack and interrupt control block
package pcsic_pkg;
    localparam int PC_W = 13;
    localparam int TGT_W = 11;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int OFS_W = 7;
    localparam int HI_W = PC_W - DATA_W;
    localparam int STACK_DEPTH = 8;
    localparam int CHG_W = 4;

    // register offsets within one bank; both banks see the same storage
    localparam logic [OFS_W-1:0] OFS_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [OFS_W-1:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
    localparam logic [OFS_W-1:0] OFS_INDIRECT_POINTER = 7'h04;
    localparam logic [OFS_W-1:0] OFS_PROGRAM_COUNTER_HIGH_LATCH = 7'h0a;
    localparam logic [OFS_W-1:0] OFS_INTERRUPT_CONTROL = 7'h0b;

    // interrupt_control fields
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_NVM_WRITE_DONE_IRQ_ENABLE = 6;
    localparam int BIT_TIMER_OVERFLOW_IRQ_ENABLE = 5;
    localparam int BIT_EXT_PIN_IRQ_ENABLE = 4;
    localparam int BIT_PIN_CHANGE_IRQ_ENABLE = 3;
    localparam int BIT_TIMER_OVERFLOW_FLAG = 2;
    localparam int BIT_EXT_PIN_IRQ_FLAG = 1;
    localparam int BIT_PIN_CHANGE_FLAG = 0;
    localparam logic [DATA_W-1:0] INTERRUPT_CONTROL_RESET = 8'h00;

    // page-select field of the high latch, and which latch bits feed pc<12:8>
    localparam int PAGE_LSB = 3;
    localparam int PAGE_W = 2;
    localparam logic [DATA_W-1:0] PAGE_IGNORE_MASK = 8'h07;

    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [PC_W-1:0] IRQ_VECTOR_DEFAULT = 13'h0004;

    // one instruction-level event from the execute logic; at most one bit set
    typedef struct packed {
        logic call;
        logic jump;
        logic ret;
        logic ret_irq;
        logic irq_ack;
        logic step;
        logic [TGT_W-1:0] target;
    } pcsic_cmd_t;
endpackage : pcsic_pkg

/* hw/pcsic_stack.sv */
// circular return-address stack
`timescale 1ns/1ps
module pcsic_stack #(
    parameter int DEPTH = pcsic_pkg::STACK_DEPTH,
    parameter int WIDTH = pcsic_pkg::PC_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [WIDTH-1:0] push_data_i,
    output logic [WIDTH-1:0] top_o
);
    localparam int PTR_W = $clog2(DEPTH);

    // pointer wrap relies on plain overflow, so only power-of-two depths work
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("pcsic_stack: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] entry;
        logic [PTR_W-1:0] ptr;
    } pcsic_stack_state_t;

    pcsic_stack_state_t state;
    pcsic_stack_state_t next_state;

    // pointer is invisible to software and nothing reports over/underflow
    assign top_o = state.entry[state.ptr - PTR_W'(1)];

    always_comb begin
        next_state = state;
        if (push_i) begin
            // wraps: push nine overwrites push one
            next_state.entry[state.ptr] = push_data_i;
            next_state.ptr = state.ptr + PTR_W'(1);
        end else if (pop_i) begin
            // wraps: pop nine returns what pop one did
            next_state.ptr = state.ptr - PTR_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule : pcsic_stack

/* hw/pcsic_top.sv */
// program counter, return stack, interrupt control and indirect addressing
`timescale 1ns/1ps
module pcsic_top #(
    parameter int STACK_DEPTH = pcsic_pkg::STACK_DEPTH,
    parameter logic [pcsic_pkg::PC_W-1:0] IRQ_VECTOR = pcsic_pkg::IRQ_VECTOR_DEFAULT
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [pcsic_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [pcsic_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [pcsic_pkg::DATA_W-1:0] RDATA_O,
    input wire pcsic_pkg::pcsic_cmd_t CMD_I,
    input wire logic TIMER_OVF_I,
    input wire logic EXT_PIN_EVT_I,
    input wire logic NVM_DONE_FLAG_I,
    input wire logic [pcsic_pkg::CHG_W-1:0] CHG_PINS_I,
    input wire logic PORT_RD_I,
    output logic [pcsic_pkg::PC_W-1:0] PC_O,
    output logic IRQ_REQ_O,
    output logic [pcsic_pkg::ADDR_W-1:0] FILE_RADDR_O,
    input wire logic [pcsic_pkg::DATA_W-1:0] FILE_RDATA_I,
    output logic [pcsic_pkg::ADDR_W-1:0] FILE_WADDR_O,
    output logic [pcsic_pkg::DATA_W-1:0] FILE_WDATA_O,
    output logic FILE_WR_O
);
    localparam int PC_W = pcsic_pkg::PC_W;
    localparam int DATA_W = pcsic_pkg::DATA_W;
    localparam int ADDR_W = pcsic_pkg::ADDR_W;
    localparam int OFS_W = pcsic_pkg::OFS_W;
    localparam int HI_W = pcsic_pkg::HI_W;
    localparam int TGT_W = pcsic_pkg::TGT_W;
    localparam int CHG_W = pcsic_pkg::CHG_W;

    // the stack pointer wraps by overflow, so only power-of-two depths work
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("pcsic_top: STACK_DEPTH must be a power of two, at least 2");
    end
    // upper pages do not exist, so the vector must sit in page zero
    if (IRQ_VECTOR[PC_W-1:TGT_W] != '0) begin : g_bad_vector
        $error("pcsic_top: IRQ_VECTOR must lie below the first page boundary");
    end

    typedef struct packed {
        logic [DATA_W-1:0] interrupt_control;
        logic [DATA_W-1:0] program_counter_high_latch;
        logic [DATA_W-1:0] indirect_pointer;
        logic [PC_W-1:0] pc;
        logic [CHG_W-1:0] change_snapshot;
        logic [DATA_W-1:0] rdata;
        logic irq_req;
        logic [ADDR_W-1:0] file_waddr;
        logic [DATA_W-1:0] file_wdata;
        logic file_wr;
    } pcsic_state_t;

    pcsic_state_t state;
    pcsic_state_t next_state;

    logic [PC_W-1:0] stack_top;
    logic stack_push;
    logic stack_pop;

    // effective register offset, and whether an access went through the port
    logic via_port;
    logic [ADDR_W-1:0] eff_addr;
    logic [OFS_W-1:0] eff_ofs;
    logic eff_is_port;
    logic eff_local;
    logic [DATA_W-1:0] local_rdata;
    logic [DATA_W-1:0] latch_hi;
    logic [PC_W-1:0] loaded_target;
    logic pin_mismatch;
    logic [DATA_W-1:0] ic;

    // push on call or acknowledge, pop on either return kind
    assign stack_push = CMD_I.call | CMD_I.irq_ack;
    assign stack_pop = CMD_I.ret | CMD_I.ret_irq;

    pcsic_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_W)
    ) u_stack (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .push_i(stack_push),
        .pop_i(stack_pop),
        .push_data_i(state.pc),
        .top_o(stack_top)
    );

    always_comb begin
        // port offset in either bank redirects through the pointer
        via_port = ADDR_I[OFS_W-1:0] == pcsic_pkg::OFS_INDIRECT_DATA_PORT;
        eff_addr = via_port ? state.indirect_pointer : ADDR_I;
        eff_ofs = eff_addr[OFS_W-1:0];
        eff_is_port = eff_ofs == pcsic_pkg::OFS_INDIRECT_DATA_PORT;
        // bank bit dropped, so 0Bh and 8Bh land on one register
        unique case (eff_ofs)
            pcsic_pkg::OFS_INDIRECT_DATA_PORT,
            pcsic_pkg::OFS_PROGRAM_COUNTER_LOW,
            pcsic_pkg::OFS_INDIRECT_POINTER,
            pcsic_pkg::OFS_PROGRAM_COUNTER_HIGH_LATCH,
            pcsic_pkg::OFS_INTERRUPT_CONTROL: eff_local = 1'b1;
            default: eff_local = 1'b0;
        endcase
        unique case (eff_ofs)
            pcsic_pkg::OFS_PROGRAM_COUNTER_LOW: local_rdata = state.pc[DATA_W-1:0];
            pcsic_pkg::OFS_INDIRECT_POINTER: local_rdata = state.indirect_pointer;
            pcsic_pkg::OFS_PROGRAM_COUNTER_HIGH_LATCH: begin
                local_rdata = state.program_counter_high_latch;
            end
            pcsic_pkg::OFS_INTERRUPT_CONTROL: local_rdata = state.interrupt_control;
            // the port reads as zero when it points at itself
            default: local_rdata = pcsic_pkg::ZERO_BYTE;
        endcase
    end

    always_comb begin
        // page bits of the latch take no part in any load on this part
        latch_hi = state.program_counter_high_latch & pcsic_pkg::PAGE_IGNORE_MASK;
        // call and jump: 11-bit target, pc<12:11> zero since the page bits are masked
        loaded_target = {latch_hi[HI_W-1:TGT_W-DATA_W], CMD_I.target};
        pin_mismatch = |(CHG_PINS_I ^ state.change_snapshot);
    end

    always_comb begin
        next_state = state;
        next_state.file_wr = 1'b0;
        ic = state.interrupt_control;

        // counter sequencing; only the low byte is software visible
        if (CMD_I.call || CMD_I.jump) begin
            next_state.pc = loaded_target;
        end else if (CMD_I.irq_ack) begin
            next_state.pc = IRQ_VECTOR;
        end else if (stack_pop) begin
            next_state.pc = stack_top;
        end else if (CMD_I.step) begin
            next_state.pc = state.pc + pcsic_pkg::PC_ONE;
        end
        // a return from interrupt re-opens the global gate
        if (CMD_I.ret_irq) begin
            ic[pcsic_pkg::BIT_GLOBAL_IRQ_ENABLE] = 1'b1;
        end

        // the latch is never touched by push or pop
        if (WR_I) begin
            if (via_port) begin
                if (!eff_local) begin
                    // off-block target: forward, one cycle late but ordered
                    next_state.file_wr = 1'b1;
                    next_state.file_waddr = eff_addr;
                    next_state.file_wdata = WDATA_I;
                end
            end
            // writes that land on the port itself fall through as no-op
            if (eff_local && !eff_is_port) begin
                unique case (eff_ofs)
                    pcsic_pkg::OFS_PROGRAM_COUNTER_LOW: begin
                        // low byte write also loads 10:8 from the latch and clears 12:11
                        next_state.pc = {latch_hi[HI_W-1:0], WDATA_I};
                    end
                    pcsic_pkg::OFS_INDIRECT_POINTER: next_state.indirect_pointer = WDATA_I;
                    pcsic_pkg::OFS_PROGRAM_COUNTER_HIGH_LATCH: begin
                        next_state.program_counter_high_latch = WDATA_I;
                    end
                    pcsic_pkg::OFS_INTERRUPT_CONTROL: ic = WDATA_I;
                    default: ;
                endcase
            end
        end

        // flags set after the software write so a same-cycle event wins
        if (TIMER_OVF_I) begin
            ic[pcsic_pkg::BIT_TIMER_OVERFLOW_FLAG] = 1'b1;
        end
        if (EXT_PIN_EVT_I) begin
            ic[pcsic_pkg::BIT_EXT_PIN_IRQ_FLAG] = 1'b1;
        end
        // a standing mismatch keeps setting the flag until the port is read
        if (pin_mismatch) begin
            ic[pcsic_pkg::BIT_PIN_CHANGE_FLAG] = 1'b1;
        end
        next_state.interrupt_control = ic;
        if (PORT_RD_I) begin
            next_state.change_snapshot = CHG_PINS_I;
        end

        // enables gate only the request, never the flags
        next_state.irq_req = ic[pcsic_pkg::BIT_GLOBAL_IRQ_ENABLE] & (
            (ic[pcsic_pkg::BIT_NVM_WRITE_DONE_IRQ_ENABLE] & NVM_DONE_FLAG_I)
            | (ic[pcsic_pkg::BIT_TIMER_OVERFLOW_IRQ_ENABLE]
               & ic[pcsic_pkg::BIT_TIMER_OVERFLOW_FLAG])
            | (ic[pcsic_pkg::BIT_EXT_PIN_IRQ_ENABLE]
               & ic[pcsic_pkg::BIT_EXT_PIN_IRQ_FLAG])
            | (ic[pcsic_pkg::BIT_PIN_CHANGE_IRQ_ENABLE]
               & ic[pcsic_pkg::BIT_PIN_CHANGE_FLAG]));

        // read data stands only in the cycle after the strobe
        if (RD_I) begin
            if (eff_local) begin
                next_state.rdata = local_rdata;
            end else if (via_port) begin
                // file answers at the pointer address without waiting
                next_state.rdata = FILE_RDATA_I;
            end else begin
                next_state.rdata = pcsic_pkg::ZERO_BYTE;
            end
        end else begin
            next_state.rdata = pcsic_pkg::ZERO_BYTE;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= '0;
            // bit 0 is undefined by spec; it clears here for determinism
            state.interrupt_control <= pcsic_pkg::INTERRUPT_CONTROL_RESET;
            state.pc <= pcsic_pkg::PC_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign RDATA_O = state.rdata;
    assign PC_O = state.pc;
    assign IRQ_REQ_O = state.irq_req;
    assign FILE_RADDR_O = state.indirect_pointer;
    assign FILE_WADDR_O = state.file_waddr;
    assign FILE_WDATA_O = state.file_wdata;
    assign FILE_WR_O = state.file_wr;
endmodule : pcsic_top

/* verification/pcsic_top_asserts.sv */
// concurrent checks on the ports of the pc, stack and interrupt control block
`timescale 1ns/1ps
module pcsic_top_asserts #(
    parameter logic [pcsic_pkg::PC_W-1:0] IRQ_VECTOR = pcsic_pkg::IRQ_VECTOR_DEFAULT
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire pcsic_pkg::pcsic_cmd_t CMD_I,
    input wire logic TIMER_OVF_I,
    input wire logic EXT_PIN_EVT_I,
    input wire logic NVM_DONE_FLAG_I,
    input wire logic [12:0] PC_O,
    input wire logic IRQ_REQ_O,
    input wire logic [7:0] FILE_RADDR_O,
    input wire logic [7:0] FILE_WADDR_O,
    input wire logic [7:0] FILE_WDATA_O,
    input wire logic FILE_WR_O
);
    logic [7:3] en_q;
    logic ptr_ext;
    logic ind;
    assign ind = ADDR_I[6:0] == 7'h00;
    assign ptr_ext = !(FILE_RADDR_O[6:0] inside {7'h00, 7'h02, 7'h04, 7'h0a, 7'h0b});
    // shadow of the enables; indirect writes to the control register are not tracked
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            en_q <= 5'h00;
        end else if (WR_I && ADDR_I[6:0] == 7'h0b) begin
            en_q <= WDATA_I[7:3];
        end else if (CMD_I.ret_irq) begin
            en_q[7] <= 1'b1;
        end
    end
    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    a_gie_blocks_all: assert property (!en_q[7] |-> !IRQ_REQ_O)
        else $error("irq request with global enable clear");
    a_nvm_irq_raise: assert property (en_q[7] && en_q[6] && $past(NVM_DONE_FLAG_I)
        |-> IRQ_REQ_O)
        else $error("nvm done did not raise irq");
    a_timer_irq_raise: assert property (TIMER_OVF_I && en_q[7] && en_q[5] && !WR_I
        |=> IRQ_REQ_O)
        else $error("timer overflow did not raise irq");
    a_ext_irq_raise: assert property (EXT_PIN_EVT_I && en_q[7] && en_q[4] && !WR_I
        |=> IRQ_REQ_O)
        else $error("external pin event did not raise irq");
    a_branch_target: assert property ((CMD_I.call || CMD_I.jump) && !WR_I
        |=> PC_O == {2'b00, $past(CMD_I.target)})
        else $error("call or jump target wrong");
    a_step_increment: assert property (CMD_I.step && !WR_I
        |=> PC_O == $past(PC_O) + 13'h0001)
        else $error("step did not increment pc");
    a_pcl_load: assert property (WR_I && ADDR_I[6:0] == 7'h02
        |=> PC_O[7:0] == $past(WDATA_I) && PC_O[12:11] == 2'b00)
        else $error("low byte write did not load pc");
    a_irq_vector_load: assert property (CMD_I.irq_ack && !WR_I |=> PC_O == IRQ_VECTOR)
        else $error("irq acknowledge did not load vector");
    a_call_return_pair: assert property (CMD_I.call && !WR_I ##1 CMD_I == '0 && !WR_I
        ##1 CMD_I.ret && !WR_I |=> PC_O == $past(PC_O, 3))
        else $error("return did not restore pc of call");
    a_indir_fwd_write: assert property (WR_I && ind && ptr_ext
        |=> FILE_WR_O && FILE_WADDR_O == $past(FILE_RADDR_O) && FILE_WDATA_O == $past(WDATA_I))
        else $error("indirect write not forwarded");
    a_indir_zero_read: assert property (RD_I && ind && FILE_RADDR_O[6:0] == 7'h00
        |=> RDATA_O == 8'h00)
        else $error("indirect read at pointer zero not zero");
    a_indir_self_write: assert property (WR_I && ind && FILE_RADDR_O[6:0] == 7'h00
        |=> !FILE_WR_O)
        else $error("indirect write at pointer zero forwarded");
    c_irq_ack: cover property (CMD_I.irq_ack);
    c_irq_req: cover property (IRQ_REQ_O);
    c_file_wr: cover property (FILE_WR_O);
endmodule : pcsic_top_asserts

bind pcsic_top pcsic_top_asserts #(.IRQ_VECTOR(IRQ_VECTOR)) u_asserts (.MCLK_I(MCLK_I),
    .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .CMD_I(CMD_I), .TIMER_OVF_I(TIMER_OVF_I),
    .EXT_PIN_EVT_I(EXT_PIN_EVT_I), .NVM_DONE_FLAG_I(NVM_DONE_FLAG_I), .PC_O(PC_O),
    .IRQ_REQ_O(IRQ_REQ_O), .FILE_RADDR_O(FILE_RADDR_O), .FILE_WADDR_O(FILE_WADDR_O),
    .FILE_WDATA_O(FILE_WDATA_O), .FILE_WR_O(FILE_WR_O));

/* verification/pcsic_file_model.sv */
// outside register file reached through the indirect data port
`timescale 1ns/1ps
module pcsic_file_model (
    input wire logic clk_i,
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i
);
    logic [7:0] mem [256];
    // unwritten cells hold the inverse of their address, so only cell FFh starts at zero
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~8'(i);
        end
    end
    assign rdata_o = mem[raddr_i];
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule : pcsic_file_model

/* verification/tb_top.sv */
// self-checking bench of the pc, stack and interrupt control block
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, fraddr, fwaddr, fwdata, frdata;
    logic wr = 1'b0, rd = 1'b0, tovf = 1'b0, ext = 1'b0, nvm = 1'b0, prd = 1'b0, irq, fwr;
    logic [3:0] chg = 4'h0;
    logic [12:0] pc;
    pcsic_pkg::pcsic_cmd_t cmd = '0;
    int fail_count = 0;
    int n_compared = 0;
    initial forever #10 mclk = ~mclk;
    pcsic_top DUT (.MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .CMD_I(cmd), .TIMER_OVF_I(tovf), .EXT_PIN_EVT_I(ext),
        .NVM_DONE_FLAG_I(nvm), .CHG_PINS_I(chg), .PORT_RD_I(prd), .PC_O(pc), .IRQ_REQ_O(irq),
        .FILE_RADDR_O(fraddr), .FILE_RDATA_I(frdata), .FILE_WADDR_O(fwaddr),
        .FILE_WDATA_O(fwdata), .FILE_WR_O(fwr));
    pcsic_file_model u_file (.clk_i(mclk), .raddr_i(fraddr), .rdata_o(frdata),
        .waddr_i(fwaddr), .wdata_i(fwdata), .wr_i(fwr));
    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk("read data", {5'h00, exp}, {5'h00, rdata});
    endtask : rd_reg
    task automatic do_cmd(input logic [5:0] kind, input logic [10:0] tgt, input logic [12:0] exp);
        @(posedge mclk);
        cmd <= {kind, tgt};
        @(posedge mclk);
        cmd <= '0;
        #1;
        chk("program counter", exp, pc);
    endtask : do_cmd
    // which: 0 timer overflow, 1 external pin, 2 port read snapshot
    task automatic pulse(input int which);
        @(posedge mclk);
        tovf <= (which == 0);
        ext <= (which == 1);
        prd <= (which == 2);
        @(posedge mclk);
        tovf <= 1'b0;
        ext <= 1'b0;
        prd <= 1'b0;
        #1;
    endtask : pulse
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(8'h0b, 8'h00);
        wr_reg(8'h0b, 8'hf8);
        rd_reg(8'h8b, 8'hf8);
        wr_reg(8'h8b, 8'h00);
        pulse(0);
        pulse(1);
        chk("irq request", 13'h0000, {12'h000, irq});
        rd_reg(8'h0b, 8'h06);
        pulse(2);
        wr_reg(8'h0b, 8'h00);
        @(posedge mclk);
        chg <= 4'h5;
        rd_reg(8'h0b, 8'h01);
        pulse(2);
        wr_reg(8'h0b, 8'h00);
        rd_reg(8'h0b, 8'h00);
        wr_reg(8'h0b, 8'ha0);
        pulse(0);
        chk("irq request", 13'h0001, {12'h000, irq});
        wr_reg(8'h0b, 8'h24);
        chk("irq request", 13'h0000, {12'h000, irq});
        wr_reg(8'h0b, 8'h90);
        pulse(1);
        chk("irq request", 13'h0001, {12'h000, irq});
        wr_reg(8'h0b, 8'hc0);
        @(posedge mclk);
        nvm <= 1'b1;
        @(posedge mclk);
        #1;
        chk("irq request", 13'h0001, {12'h000, irq});
        wr_reg(8'h0b, 8'h80);
        chk("irq request", 13'h0000, {12'h000, irq});
        @(posedge mclk);
        nvm <= 1'b0;
        // pin change source: a fresh mismatch must raise the request by itself
        wr_reg(8'h0b, 8'h88);
        @(posedge mclk);
        chg <= 4'ha;
        @(posedge mclk);
        #1;
        chk("irq request", 13'h0001, {12'h000, irq});
        pulse(2);
        wr_reg(8'h0b, 8'h00);
        wr_reg(8'h0a, 8'h18);
        do_cmd(6'h01, 11'h000, 13'h0001);
        do_cmd(6'h20, 11'h123, 13'h0123);
        do_cmd(6'h08, 11'h000, 13'h0001);
        do_cmd(6'h10, 11'h7ff, 13'h07ff);
        wr_reg(8'h0a, 8'h1f);
        wr_reg(8'h02, 8'h55);
        chk("program counter", 13'h0755, pc);
        rd_reg(8'h02, 8'h55);
        do_cmd(6'h02, 11'h000, 13'h0004);
        do_cmd(6'h04, 11'h000, 13'h0755);
        rd_reg(8'h0b, 8'h80);
        // nine calls wrap the eight-deep stack, then nine pops wrap back
        for (int i = 0; i < 9; i++) begin
            do_cmd(6'h20, 11'(11'h100 + i), 13'(13'h100 + i));
        end
        for (int k = 0; k < 9; k++) begin
            do_cmd(6'h08, 11'h000, 13'(13'h107 - k % 8));
        end
        rd_reg(8'h8a, 8'h1f);
        wr_reg(8'h04, 8'h20);
        wr_reg(8'h00, 8'h5a);
        chk("file write strobe", 13'h0001, {12'h000, fwr});
        chk("file write address", 13'h0020, {5'h00, fwaddr});
        rd_reg(8'h80, 8'h5a);
        wr_reg(8'h84, 8'h0b);
        rd_reg(8'h00, 8'h80);
        wr_reg(8'h04, 8'h00);
        wr_reg(8'h00, 8'h33);
        chk("file write strobe", 13'h0000, {12'h000, fwr});
        rd_reg(8'h00, 8'h00);
        rd_reg(8'h07, 8'h00);
        tally_and_finish();
    end
endmodule : tb_top
